// file: rtl/rsmf_defines.vh
// Constants for the rate sensor message framer
`ifndef RSMF_DEFINES_VH
`define RSMF_DEFINES_VH
// APB register byte offsets
`define RSMF_ADDR_CTRL     12'h000
`define RSMF_ADDR_STATUS   12'h004
`define RSMF_ADDR_RATE     12'h008
`define RSMF_ADDR_AUX1     12'h00c
`define RSMF_ADDR_AUX2     12'h010
`define RSMF_ADDR_TEMP     12'h014
`define RSMF_ADDR_CFG1     12'h018
`define RSMF_ADDR_CFG2     12'h01c
`define RSMF_ADDR_LASTRX   12'h020
`define RSMF_ADDR_LASTRXHI 12'h024
// Control register fields
`define RSMF_CTRL_FAIL     0
`define RSMF_CTRL_FCLR     1
// Status byte field positions
`define RSMF_ST_CNT_HI     7
`define RSMF_ST_CNT_LO     6
`define RSMF_ST_HCF        5
`define RSMF_ST_FAIL       4
`define RSMF_ST_STEST      3
// Control byte fields
`define RSMF_CB_STEST      3
// Message types
`define RSMF_MT_RATE       3'h0
`define RSMF_MT_AUX1       3'h1
`define RSMF_MT_AUX2       3'h2
`define RSMF_MT_TEMP       3'h3
`define RSMF_MT_CFG1       3'h4
`define RSMF_MT_CFG2       3'h5
// Frame geometry
`define RSMF_FRAME_BITS    6'd48
`define RSMF_LAST_BIT      6'd47
// Reset values
`define RSMF_RST_TYPE      3'h4
`define RSMF_RST_CFG       32'h0000_0000
`endif

// file: rtl/rsmf_framer.v
// Rate sensor SPI message framer with APB register access
//
// Summary of operation
// - Control bit 3 commands self-test
// - Control bits 2:0 pick next type
// - Checksum is complement of bytes 0-4 sum
// - Reply: status, four data, checksum
// - Status 7:6 count full-length messages
// - Status 5 flags host comm fault
// - Status 4 flags built-in test failure
// - Status 3 shows self-test active
// - Status 2:0 give current type
// - Data follow previous frame's request
// - Basic: rate, check byte, reserved
// - Aux types: rate then signed aux
// - Temperature type: rate then temperature
// - Config one: range, bandwidth, variant, version, year
// - Config two: month, lot, plant, serial
// - Bad frame keeps last valid type
// - Config one after reset until valid
// - Select high: output released, inputs ignored
// - Full duplex 48-bit exchange
// - Check byte derived from previous low rate
`timescale 1ns/100ps
`include "rsmf_defines.vh"
module rsmf_framer (
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // SPI link pins
  input  wire        spi_sel_n,
  input  wire        spi_clk,
  input  wire        spi_mosi,
  output reg         spi_miso_o,
  output reg         spi_miso_oe_n,
  // Sensor side
  output reg         commanded_selftest
);

  reg  [2:0]  sel_s_q;
  reg  [2:0]  clk_s_q;
  reg  [1:0]  mosi_s_q;
  reg  [47:0] rx_q;
  reg  [47:0] tx_q;
  reg  [5:0]  bit_q;
  reg         active_q;
  reg  [2:0]  next_type_q;
  reg  [2:0]  cur_type_q;
  reg  [1:0]  msg_counter_q;
  reg         host_comm_fault_q;
  reg         selftest_fail_q;
  reg         fclr_req_q;
  reg  [15:0] rate_q;
  reg  [15:0] aux1_q;
  reg  [15:0] aux2_q;
  reg  [15:0] temp_q;
  reg  [31:0] cfg1_q;
  reg  [31:0] cfg2_q;
  reg  [7:0]  prev_rate_lo_q;
  reg  [47:0] last_rx_q;

  wire sel_act  = ~sel_s_q[1];
  wire sel_rise = sel_s_q[1] & ~sel_s_q[2];
  wire sel_fall = ~sel_s_q[1] & sel_s_q[2];
  // Mode 0 style: sample on rising, shift on falling
  wire clk_rise = clk_s_q[1] & ~clk_s_q[2];
  wire clk_fall = ~clk_s_q[1] & clk_s_q[2];

  function [7:0] csum;
    input [39:0] b;
    begin
      csum = ~(b[39:32] + b[31:24] + b[23:16] + b[15:8] + b[7:0]);
    end
  endfunction

  // fixed test calculation, host repeats it
  function [7:0] rchk;
    input [7:0] r;
    reg   [7:0] swp;
    begin
      // Swap, mix, add, subtract: touches each ALU path
      swp  = {r[3:0], r[7:4]} ^ 8'h5a;
      rchk = (swp + (r << 1)) - (r >> 2);
    end
  endfunction

  // Host frame decode
  wire [7:0] rx_ctl  = rx_q[47:40];
  wire [7:0] rx_sum  = rx_q[7:0];
  wire       rx_good;
  // reserved type codes rejected
  // Codes above the last defined type are reserved
  assign rx_good = (rx_sum == csum(rx_q[47:8])) &
                   (rx_ctl[2:0] <= `RSMF_MT_CFG2);

  // Reply assembly
  reg [31:0] data_w;
  reg [7:0]  status_w;
  always @*
  begin
    // data follow the type latched last frame
    case (next_type_q)
      `RSMF_MT_RATE: data_w = {rate_q, rchk(prev_rate_lo_q), 8'h00};
      `RSMF_MT_AUX1: data_w = {rate_q, aux1_q};
      `RSMF_MT_AUX2: data_w = {rate_q, aux2_q};
      `RSMF_MT_TEMP: data_w = {rate_q, temp_q};
      `RSMF_MT_CFG1: data_w = {cfg1_q[31:24], 4'h0, cfg1_q[19:16],
                               cfg1_q[15:8], 3'h0, cfg1_q[4:0]};
      `RSMF_MT_CFG2: data_w = cfg2_q;
      // Unreachable: reserved codes are never latched
      default:       data_w = {rate_q, 16'h0000};
    endcase
    status_w = 8'h00;
    status_w[`RSMF_ST_CNT_HI:`RSMF_ST_CNT_LO] = msg_counter_q;
    status_w[`RSMF_ST_HCF] = host_comm_fault_q;
    status_w[`RSMF_ST_FAIL] = selftest_fail_q;
    status_w[`RSMF_ST_STEST] = commanded_selftest;
    status_w[2:0] = next_type_q;
  end

  // Pin synchronisers
  // Third stage only feeds the edge detectors
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_s_q  <= 3'h7;
      clk_s_q  <= 3'h0;
      mosi_s_q <= 2'h0;
    end
    else
    begin
      sel_s_q  <= {sel_s_q[1:0], spi_sel_n};
      clk_s_q  <= {clk_s_q[1:0], spi_clk};
      mosi_s_q <= {mosi_s_q[0], spi_mosi};
    end
  end

  // Link engine
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_q               <= 48'h0;
      tx_q               <= 48'h0;
      bit_q              <= 6'd0;
      active_q           <= 1'b0;
      next_type_q        <= `RSMF_RST_TYPE;
      cur_type_q         <= `RSMF_RST_TYPE;
      msg_counter_q      <= 2'h0;
      host_comm_fault_q  <= 1'b0;
      commanded_selftest <= 1'b0;
      prev_rate_lo_q     <= 8'h00;
      last_rx_q          <= 48'h0;
      spi_miso_o         <= 1'b0;
      spi_miso_oe_n      <= 1'b1;
    end
    else
    begin
      spi_miso_oe_n <= ~sel_act;
      if (sel_fall)
      begin
        // Reply frozen at frame start, register writes wait
        // status then four data bytes
        tx_q       <= {status_w, data_w,
                       csum({status_w, data_w})};
        cur_type_q <= next_type_q;
        bit_q      <= 6'd0;
        active_q   <= 1'b1;
        // rate byte kept for next check
        if (next_type_q == `RSMF_MT_RATE)
          prev_rate_lo_q <= rate_q[7:0];
      end
      else if (sel_act & active_q & clk_rise)
      begin
        rx_q  <= {rx_q[46:0], mosi_s_q[1]};
        bit_q <= bit_q + 6'd1;
      end
      // Out bit moves on falling edge, settled by rising
      else if (sel_act & active_q & clk_fall)
        tx_q <= {tx_q[46:0], 1'b0};
      spi_miso_o <= tx_q[47];
      // Frame end: log every frame, count full ones, commit only a full clean frame
      if (sel_rise & active_q)
      begin
        active_q  <= 1'b0;
        last_rx_q <= rx_q;
        if (bit_q == `RSMF_FRAME_BITS)
          msg_counter_q <= msg_counter_q + 2'h1;
        if ((bit_q == `RSMF_FRAME_BITS) & rx_good)
        begin
          next_type_q        <= rx_ctl[2:0];
          commanded_selftest <= rx_ctl[`RSMF_CB_STEST];
          if (fclr_req_q)
            host_comm_fault_q <= 1'b0;
        end
        else
          host_comm_fault_q <= 1'b1;
      end
      else if (fclr_req_q)
        host_comm_fault_q <= 1'b0;
    end
  end

  // APB register file, answer in the access cycle
  // Read data taken at setup, so it stands with pready
  wire acc = psel & penable;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata          <= 32'h0;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      selftest_fail_q <= 1'b0;
      fclr_req_q      <= 1'b0;
      rate_q          <= 16'h0;
      aux1_q          <= 16'h0;
      aux2_q          <= 16'h0;
      temp_q          <= 16'h0;
      cfg1_q          <= `RSMF_RST_CFG;
      cfg2_q          <= `RSMF_RST_CFG;
    end
    else
    begin
      // Clear request is a one-cycle pulse
      fclr_req_q <= 1'b0;
      pready     <= psel & ~penable;
      pslverr    <= 1'b0;
      if (psel & ~penable)
      begin
        prdata <= 32'h0;
        case (paddr)
          `RSMF_ADDR_CTRL:     prdata <= {31'h0, selftest_fail_q};
          `RSMF_ADDR_STATUS:   prdata <= {16'h0, cur_type_q, 2'h0,
                                          next_type_q, status_w};
          `RSMF_ADDR_RATE:     prdata <= {16'h0, rate_q};
          `RSMF_ADDR_AUX1:     prdata <= {16'h0, aux1_q};
          `RSMF_ADDR_AUX2:     prdata <= {16'h0, aux2_q};
          `RSMF_ADDR_TEMP:     prdata <= {16'h0, temp_q};
          `RSMF_ADDR_CFG1:     prdata <= cfg1_q;
          `RSMF_ADDR_CFG2:     prdata <= cfg2_q;
          `RSMF_ADDR_LASTRX:   prdata <= last_rx_q[31:0];
          `RSMF_ADDR_LASTRXHI: prdata <= {16'h0, last_rx_q[47:32]};
          default:             pslverr <= 1'b1;
        endcase
      end
      if (acc & pready & pwrite)
      begin
        case (paddr)
          `RSMF_ADDR_CTRL:
          begin
            selftest_fail_q <= pwdata[`RSMF_CTRL_FAIL];
            fclr_req_q      <= pwdata[`RSMF_CTRL_FCLR];
          end
          `RSMF_ADDR_RATE: rate_q <= pwdata[15:0];
          `RSMF_ADDR_AUX1: aux1_q <= pwdata[15:0];
          `RSMF_ADDR_AUX2: aux2_q <= pwdata[15:0];
          `RSMF_ADDR_TEMP: temp_q <= pwdata[15:0];
          `RSMF_ADDR_CFG1: cfg1_q <= pwdata;
          `RSMF_ADDR_CFG2: cfg2_q <= pwdata;
          default:         fclr_req_q <= 1'b0;
        endcase
      end
    end
  end

endmodule // rsmf_framer

// file: tb/rsmf_framer_properties.sv
// Checker for the framer's bus and link ports
`timescale 1ns/100ps
module rsmf_framer_props (
  // APB
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  // Link
  input wire        spi_sel_n,
  input wire        spi_miso_oe_n,
  input wire        commanded_selftest
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_needs_sel: assert property (!psel |=> !pready)
    else $error("ready without select");
  a_err_unmapped: assert property
    (psel && !penable && paddr > 12'h024 |=> pslverr)
    else $error("unmapped access not refused");
  a_err_only_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_released_idle: assert property
    (spi_sel_n [*4] |-> spi_miso_oe_n)
    else $error("data out driven while idle");
  a_drive_in_frame: assert property
    ($fell(spi_sel_n) |-> ##[2:8] !spi_miso_oe_n)
    else $error("data out not driven in frame");
  a_selftest_frozen: assert property
    (!spi_sel_n && $past(!spi_sel_n) |-> $stable(commanded_selftest))
    else $error("self-test changed inside frame");
endmodule // rsmf_framer_props

bind rsmf_framer rsmf_framer_props rsmf_framer_props_inst (.pclk, .presetn,
  .psel, .penable, .paddr, .pready, .pslverr, .spi_sel_n, .spi_miso_oe_n,
  .commanded_selftest);

// file: tb/rsmf_host_model.sv
// Host-side serial master model running framed exchanges
`timescale 1ns/100ps
module rsmf_host_model (
  // Link
  output reg  spi_sel_n,
  output reg  spi_clk,
  output reg  spi_mosi,
  input  wire spi_miso_o,
  input  wire spi_miso_oe_n
);
  initial
  begin
    spi_sel_n = 1'b1;
    spi_clk   = 1'b0;
    spi_mosi  = 1'b1;
  end
  task xfer(input [47:0] tx, input integer n, output [47:0] rx);
    integer i;
    begin
      rx = 48'h0;
      // 7.5 ns offset keeps link edges off pclk rising edges
      #7.5 spi_sel_n = 1'b0;
      #40;
      for (i = 47; i > 47 - n; i = i - 1)
      begin
        spi_mosi = tx[i];
        #24 spi_clk = 1'b1;
        // Released line reads as the complement of the bit being sent
        rx[i] = spi_miso_oe_n ? ~spi_mosi : spi_miso_o;
        #24 spi_clk = 1'b0;
      end
      #30 spi_sel_n = 1'b1;
      spi_mosi = ~spi_mosi;
      #150;
    end
  endtask
endmodule // rsmf_host_model

// file: tb/rsmf_framer_test.sv
// Self-checking bench for the rate sensor message framer
`timescale 1ns/100ps
module rsmf_framer_test;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire        pready, pslverr, spi_sel_n, spi_clk, spi_mosi;
  wire        spi_miso_o, spi_miso_oe_n, commanded_selftest;
  integer     n_errors = 0;
  integer     n_compared = 0;
  integer     seed = 32'hffbc1603;
  integer     i;
  reg  [31:0] regs [2:7];
  reg  [31:0] q;
  reg  [47:0] rx;
  reg  [1:0]  cnt;
  reg  [2:0]  ty;
  reg  [7:0]  rlo;
  reg         st, flt, fail, err;

  always #2.5 pclk = ~pclk;

  rsmf_framer rsmf_framer_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .spi_sel_n, .spi_clk,
    .spi_mosi, .spi_miso_o, .spi_miso_oe_n, .commanded_selftest);
  rsmf_host_model rsmf_host_model_inst (.spi_sel_n, .spi_clk, .spi_mosi,
    .spi_miso_o, .spi_miso_oe_n);

  function [31:0] dat(input [2:0] t);
    reg [7:0] r, c;
    begin
      r = rlo;
      c = ({r[3:0], r[7:4]} ^ 8'h5a) + (r << 1) - (r >> 2);
      case (t)
        3'h0: dat = {regs[2][15:0], c, 8'h00};
        3'h1: dat = {regs[2][15:0], regs[3][15:0]};
        3'h2: dat = {regs[2][15:0], regs[4][15:0]};
        3'h3: dat = {regs[2][15:0], regs[5][15:0]};
        3'h4: dat = regs[6] & 32'hff0f_ff1f;
        default: dat = regs[7];
      endcase
    end
  endfunction

  function [47:0] reply(input [7:0] s, input [31:0] d);
    reply = {s, d, ~(s + d[31:24] + d[23:16] + d[15:8] + d[7:0])};
  endfunction

  task chk(input [47:0] got, input [47:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task frame(input [7:0] c, input [7:0] cs, input integer n);
    begin
      rsmf_host_model_inst.xfer({c, 32'h0, cs}, n, rx);
      if (n == 48)
      begin
        chk(rx, reply({cnt, flt, fail, st, ty}, dat(ty)));
        cnt = cnt + 2'h1;
      end
      // A basic reply latches the rate byte for the next check
      if (ty == 3'h0)
        rlo = regs[2][7:0];
      if (n == 48 && cs == ~c && c[2:0] < 3'h6)
      begin
        ty = c[2:0];
        st = c[3];
      end
      else
        flt = 1'b1;
      repeat (6) @(posedge pclk);
      chk(commanded_selftest, st);
    end
  endtask

  task test_done;
    begin
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  initial
  begin
    cnt = 2'h0;
    rlo = 8'h00;
    ty = 3'h4;
    st = 1'b0;
    flt = 1'b0;
    fail = $random(seed);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 12'h000, {31'h0, fail});
    for (i = 2; i < 8; i = i + 1)
    begin
      regs[i] = $random(seed);
      if (i < 6)
        regs[i] = regs[i] & 32'hffff;
      apb(1'b1, {i[9:0], 2'b00}, regs[i]);
      apb(1'b0, {i[9:0], 2'b00}, 32'h0);
      chk(q, regs[i]);
    end
    apb(1'b0, 12'h0fc, 32'h0);
    chk(err, 1'b1);
    // Sweep every type once, then random picks
    for (i = 0; i < 30; i = i + 1)
    begin
      q = (i < 6) ? i : {$random(seed)} % 6;
      q[3] = $random(seed);
      frame(q[7:0], ~q[7:0], 48);
    end
    frame(8'h06, 8'hf9, 48);
    frame(8'h0f, 8'hf0, 48);
    frame(8'h01, 8'h01, 48);
    frame(8'h02, 8'hfd, 40);
    frame(8'h00, 8'hff, 48);
    apb(1'b0, 12'h004, 32'h0);
    chk(q[10:0], {ty, cnt, flt, fail, st, ty});
    apb(1'b1, 12'h000, {30'h0, 1'b1, fail});
    flt = 1'b0;
    frame(8'h0d, 8'hf2, 48);
    frame(8'h00, 8'hff, 48);
    test_done;
  end

  initial
  begin
    #400000;
    n_errors = n_errors + 1;
    test_done;
  end
endmodule // rsmf_framer_test
